// ### src/dtc_top.sv
// dual eight-bit timer/counter with chaining to sixteen bits.
// assumes control and compare writes arrive as one-cycle strobes on clk_i.
//
// Overview of operation
// - timer mode counts internal ticks; match pulses interrupt, clears, continues.
// - event mode counts pin falling edges; match pulses interrupt and clears.
// - divider mode match toggles the flip-flop, clears counter, pulses interrupt.
// - divider output pin is always the inverse of the flip-flop.
// - software loads the flip-flop level; reset clears it to zero.
// - stopping holds the pin; change level only in a later write.
// - control bit 3 runs, bit 7 is flip-flop; clearing 7 stopped gives high.
// - compare writes act at once; avoid changing them while running.
// - both counters chain into one sixteen-bit counter, lower is low byte.
// - mode field decodes timer, divider, pwm, sixteen-bit kinds; 011 reserved.
`timescale 1ns/10ps
`default_nettype none

module dtc_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic low_freq_tick_i,
    input wire logic slow_mode_i,
    input wire logic prescaler_source_select_i,
    input wire logic [dtc_pkg::NUM_CH-1:0] event_input_pin_i,
    input wire logic [dtc_pkg::NUM_CH-1:0] counter_control_reg_wr_i,
    input wire logic [dtc_pkg::NUM_CH-1:0][dtc_pkg::BYTE_W-1:0] counter_control_reg_i,
    input wire logic [dtc_pkg::NUM_CH-1:0] compare_value_reg_wr_i,
    input wire logic [dtc_pkg::NUM_CH-1:0][dtc_pkg::BYTE_W-1:0] compare_value_reg_i,
    output logic [dtc_pkg::NUM_CH-1:0][dtc_pkg::BYTE_W-1:0] counter_control_reg_o,
    output logic [dtc_pkg::NUM_CH-1:0][dtc_pkg::BYTE_W-1:0] compare_value_reg_o,
    output logic [dtc_pkg::NUM_CH-1:0][dtc_pkg::BYTE_W-1:0] count_o,
    output logic [dtc_pkg::NUM_CH-1:0] match_interrupt_o,
    output logic [dtc_pkg::NUM_CH-1:0] divider_output_pin_o
);
    import dtc_pkg::*;

    logic [BYTE_W-1:0] ctrl_r [NUM_CH];
    logic [BYTE_W-1:0] cmp_r [NUM_CH];
    logic [BYTE_W-1:0] cnt_r [NUM_CH];
    logic irq_r [NUM_CH];
    logic tff_r [NUM_CH];

    logic chained;
    logic run_up;
    logic [WIDE_W-1:0] wide_nxt;
    logic match16;

    dtc_tick_if tk ();

    // ------------------------------------------------------------------
    // tick sources
    // ------------------------------------------------------------------
    dtc_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .low_freq_tick_i(low_freq_tick_i),
        .slow_mode_i(slow_mode_i),
        .prescaler_source_select_i(prescaler_source_select_i),
        .event_input_pin_i(event_input_pin_i),
        .tk(tk.gen)
    );

    // ------------------------------------------------------------------
    // chaining: upper mode field selects the sixteen-bit counter
    // ------------------------------------------------------------------
    assign chained = (dtc_mode_t'(ctrl_r[UPPER][CTRL_MODE_MSB:CTRL_MODE_LSB])
                      == MODE_TIMER16);
    assign run_up = ctrl_r[UPPER][CTRL_RUN_BIT];
    // lower byte is low half; only the lower tick source drives the pair
    assign wide_nxt = {cnt_r[UPPER], cnt_r[LOWER]} + 1'b1;
    assign match16 = chained && run_up && tk.tick[LOWER] &&
                     (wide_nxt == {cmp_r[UPPER], cmp_r[LOWER]});

    // ------------------------------------------------------------------
    // per-channel counter
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        dtc_mode_t mode;
        logic run;
        logic count_en;
        logic match8;
        logic [BYTE_W-1:0] nxt8;

        assign mode = dtc_mode_t'(ctrl_r[ch][CTRL_MODE_MSB:CTRL_MODE_LSB]);
        assign tk.clk_sel[ch] = dtc_clk_sel_t'(ctrl_r[ch][CTRL_CK_MSB:CTRL_CK_LSB]);
        // the chained pair starts and stops on the upper run bit
        assign run = chained ? run_up : ctrl_r[ch][CTRL_RUN_BIT];
        // pwm, warm-up and pulse modes are not counted by this block
        assign count_en = (mode == MODE_TIMER8) || (mode == MODE_DIVIDER);
        assign nxt8 = cnt_r[ch] + 1'b1;
        assign match8 = run && !chained && tk.tick[ch] && count_en &&
                        (nxt8 == cmp_r[ch]);

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                ctrl_r[ch] <= CTRL_RST;
            end else if (counter_control_reg_wr_i[ch]) begin
                ctrl_r[ch] <= counter_control_reg_i[ch];
            end
        end

        // no shadow stage: the comparator sees a new value next cycle
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cmp_r[ch] <= CMP_RST;
            end else if (compare_value_reg_wr_i[ch]) begin
                cmp_r[ch] <= compare_value_reg_i[ch];
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cnt_r[ch] <= CNT_RST;
            end else if (!run) begin
                cnt_r[ch] <= CNT_RST;
            end else if (chained) begin
                if (match16) begin
                    cnt_r[ch] <= CNT_RST;
                end else if (tk.tick[LOWER]) begin
                    cnt_r[ch] <= wide_nxt[ch*BYTE_W +: BYTE_W];
                end
            end else if (match8) begin
                cnt_r[ch] <= CNT_RST;
            end else if (tk.tick[ch] && count_en) begin
                cnt_r[ch] <= nxt8;
            end
        end

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                irq_r[ch] <= 1'b0;
            end else if (chained) begin
                irq_r[ch] <= (ch == UPPER) && match16;
            end else begin
                irq_r[ch] <= match8;
            end
        end

        // a write loads the level only while stopped, so the write that
        // stops the counter leaves the pin where it was
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                tff_r[ch] <= TFF_RST;
            end else if (counter_control_reg_wr_i[ch] && !ctrl_r[ch][CTRL_RUN_BIT]) begin
                tff_r[ch] <= counter_control_reg_i[ch][CTRL_FF_BIT];
            end else if (match8 && (mode == MODE_DIVIDER)) begin
                tff_r[ch] <= !tff_r[ch];
            end
        end

        // ------------------------------------------------------------------
        // outputs
        // ------------------------------------------------------------------
        assign counter_control_reg_o[ch] = ctrl_r[ch];
        assign compare_value_reg_o[ch] = cmp_r[ch];
        assign count_o[ch] = cnt_r[ch];
        assign match_interrupt_o[ch] = irq_r[ch];
        assign divider_output_pin_o[ch] = !tff_r[ch];
    end

endmodule // dtc_top

`default_nettype wire

// ### inc/dtc_pkg.sv
// dual eight-bit timer/counter: shared constants and encodings.
// assumes one 100 MHz system clock that also serves as the high-frequency clock.
`default_nettype none

package dtc_pkg;

    // ------------------------------------------------------------------
    // structure
    // ------------------------------------------------------------------
    localparam int NUM_CH = 2;
    localparam int LOWER = 0;
    localparam int UPPER = 1;
    localparam int BYTE_W = 8;
    localparam int WIDE_W = 16;
    localparam int PRESC_W = 11;
    localparam int FS_DIV_W = 3;
    localparam int SYNC_W = 3;

    // ------------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------------
    localparam int CTRL_FF_BIT = 7;
    localparam int CTRL_CK_MSB = 6;
    localparam int CTRL_CK_LSB = 4;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_MODE_MSB = 2;
    localparam int CTRL_MODE_LSB = 0;

    localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
    localparam logic [BYTE_W-1:0] CMP_RST = 8'h00;
    localparam logic [BYTE_W-1:0] CNT_RST = 8'h00;
    localparam logic TFF_RST = 1'b0;

    // ------------------------------------------------------------------
    // prescaler tap exponents of the high-frequency clock
    // ------------------------------------------------------------------
    localparam int TAP_SLOW = 11;
    localparam int TAP_D7 = 7;
    localparam int TAP_D5 = 5;
    localparam int TAP_D3 = 3;

    typedef enum logic [2:0] {
        MODE_TIMER8 = 3'h0,
        MODE_DIVIDER = 3'h1,
        MODE_PWM8 = 3'h2,
        MODE_RSVD = 3'h3,
        MODE_TIMER16 = 3'h4,
        MODE_WARMUP = 3'h5,
        MODE_PWM16 = 3'h6,
        MODE_PULSE16 = 3'h7
    } dtc_mode_t;

    typedef enum logic [2:0] {
        CK_SLOWEST = 3'h0,
        CK_FC_D7 = 3'h1,
        CK_FC_D5 = 3'h2,
        CK_FC_D3 = 3'h3,
        CK_FS = 3'h4,
        CK_FC_D2 = 3'h5,
        CK_FC = 3'h6,
        CK_PIN = 3'h7
    } dtc_clk_sel_t;

endpackage

`default_nettype wire

// ### inc/dtc_tick_if.sv
// clock-select requests and count strobes between counter core and tick generator.
// assumes both ends sit in the one system clock domain.
`timescale 1ns/10ps
`default_nettype none

interface dtc_tick_if;
    import dtc_pkg::*;

    dtc_clk_sel_t clk_sel [NUM_CH];
    logic [NUM_CH-1:0] tick;

    modport gen (input clk_sel, output tick);
    modport cnt (output clk_sel, input tick);
endinterface

`default_nettype wire

// ### src/dtc_tick_gen.sv
// tick generator: prescaler taps, low-frequency taps and event pin edges.
// assumes low_freq_tick_i is a one-cycle strobe per low-frequency period.
`timescale 1ns/10ps
`default_nettype none

module dtc_tick_gen (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic low_freq_tick_i,
    input wire logic slow_mode_i,
    input wire logic prescaler_source_select_i,
    input wire logic [dtc_pkg::NUM_CH-1:0] event_input_pin_i,
    dtc_tick_if.gen tk
);
    import dtc_pkg::*;

    logic [PRESC_W-1:0] fc_div_r;
    logic [FS_DIV_W-1:0] fs_div_r;
    logic slow_tap;
    logic [NUM_CH-1:0] src_nxt;

    // ------------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fc_div_r <= '0;
        end else begin
            fc_div_r <= fc_div_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fs_div_r <= '0;
        end else if (low_freq_tick_i) begin
            fs_div_r <= fs_div_r + 1'b1;
        end
    end

    // slowest tap moves to the low-frequency clock in slow mode or when prescaler_source_select_i is set
    assign slow_tap = (slow_mode_i || prescaler_source_select_i) ?
                      (low_freq_tick_i && (&fs_div_r)) : (&fc_div_r[TAP_SLOW-1:0]);

    // every tap goes in as an argument, so the assign that calls this
    // wakes on each prescaler step and not only on a select change
    function automatic logic pick(input dtc_clk_sel_t sel, input logic fall,
                                  input logic [PRESC_W-1:0] div, input logic slow,
                                  input logic fs_tick);
        case (sel)
            CK_SLOWEST: pick = slow;
            CK_FC_D7: pick = &div[TAP_D7-1:0];
            CK_FC_D5: pick = &div[TAP_D5-1:0];
            CK_FC_D3: pick = &div[TAP_D3-1:0];
            CK_FS: pick = fs_tick;
            CK_FC_D2: pick = div[0];
            CK_FC: pick = 1'b1;
            CK_PIN: pick = fall;
            default: pick = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // event pins: synchronise, then compare successive samples
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pin
        logic [SYNC_W-1:0] sync_r;
        logic fall;

        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                sync_r <= '1;
            end else begin
                sync_r <= {sync_r[SYNC_W-2:0], event_input_pin_i[ch]};
            end
        end

        // stage 0 is only read by the shift; edge uses stages 1 and 2
        assign fall = sync_r[SYNC_W-1] && !sync_r[SYNC_W-2];
        assign src_nxt[ch] = pick(tk.clk_sel[ch], fall, fc_div_r, slow_tap, low_freq_tick_i);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tk.tick <= '0;
        end else begin
            tk.tick <= src_nxt;
        end
    end

endmodule // dtc_tick_gen

`default_nettype wire

// ### testbench/dtc_top_asserts.sv
// checker of cycle relations at the timer/counter top ports.
// assumes it is bound onto dtc_top and sees a single clock domain.
`timescale 1ns/10ps
`default_nettype none

module dtc_top_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic low_freq_tick_i,
    input wire logic slow_mode_i,
    input wire logic prescaler_source_select_i,
    input wire logic [1:0] event_input_pin_i,
    input wire logic [1:0] counter_control_reg_wr_i,
    input wire logic [1:0][7:0] counter_control_reg_i,
    input wire logic [1:0] compare_value_reg_wr_i,
    input wire logic [1:0][7:0] compare_value_reg_i,
    input wire logic [1:0][7:0] counter_control_reg_o,
    input wire logic [1:0][7:0] compare_value_reg_o,
    input wire logic [1:0][7:0] count_o,
    input wire logic [1:0] match_interrupt_o,
    input wire logic [1:0] divider_output_pin_o
);
    import dtc_pkg::*;
    wire logic [1:0] irq = match_interrupt_o;
    wire logic [1:0] pin = divider_output_pin_o;
    wire logic [1:0] wr = counter_control_reg_wr_i;
    wire logic [7:0] d1 = counter_control_reg_i[1];
    wire logic [7:0] ctl1 = counter_control_reg_o[1];
    wire logic [7:0] cmp0 = compare_value_reg_o[0];
    wire logic [7:0] cnt0 = count_o[0];
    wire logic [7:0] cnt1 = count_o[1];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // ------------------------------------------
    // lower count, upper count and divider pin
    // ------------------------------------------
    a_irq_match: assert property (irq[0] |-> cnt0 == 8'h00
        && $past(cnt0) == 8'(cmp0 - 8'h01)) else $error("lower match off compare");
    a_count_step: assert property ($changed(cnt0) |-> cnt0 == 8'h00
        || cnt0 == 8'($past(cnt0) + 8'h01)) else $error("lower count jumped");
    a_stop_clear: assert property (!ctl1[3] [*2] |-> cnt1 == 8'h00)
        else $error("stopped count not zero");
    a_irq_clear: assert property (irq[1] |-> cnt1 == 8'h00)
        else $error("upper match without clear");
    a_pin_cause: assert property ($changed(pin[1]) |-> irq[1] || $past(wr[1]))
        else $error("pin moved without cause");
    a_ff_load: assert property (wr[1] && !ctl1[3] |=> pin[1] == !$past(d1[7]))
        else $error("stopped load not inverted on pin");
    a_ff_keep: assert property (wr[1] && ctl1[3] |=> $stable(pin[1]) || irq[1])
        else $error("stopping write moved pin");
    a_div_toggle: assert property (irq[1] && ctl1[2:0] == MODE_DIVIDER
        |-> pin[1] != $past(pin[1])) else $error("divider match did not toggle");
endmodule // dtc_top_asserts

bind dtc_top dtc_top_asserts i_chk (.clk_i, .rst_b_i, .low_freq_tick_i, .slow_mode_i,
    .prescaler_source_select_i, .event_input_pin_i, .counter_control_reg_wr_i,
    .counter_control_reg_i, .compare_value_reg_wr_i, .compare_value_reg_i,
    .counter_control_reg_o, .compare_value_reg_o, .count_o, .match_interrupt_o,
    .divider_output_pin_o);

`default_nettype wire

// ### testbench/tb_dual_eight_bit_timer_counter.sv
// self-checking bench for the dual timer/counter.
// assumes dtc_pkg is compiled first; a stand-in low-frequency strobe runs throughout.
`timescale 1ns/10ps
`default_nettype none

module tb_dual_eight_bit_timer_counter;
    import dtc_pkg::*;
    logic clk_i, rst_b_i, p;
    logic [1:0] ev, cwr, mwr, irq, pin;
    logic [1:0][7:0] cd, md, ctl, cmp, cnt;
    logic [7:0] modes [5] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07};
    int n_errors = 0, n_checks = 0, cyc = 0, n, k, nev;
    int tv [3];
    int tsh [3] = '{7, 1, 5};
    logic [2:0] tsel [3] = '{3'h1, 3'h5, 3'h2};
    logic lft = 1'b0, slow = 1'b0, pss = 1'b0;
    int lfc = 0;
    localparam int LF_DIV = 10;

    dtc_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .low_freq_tick_i(lft),
        .slow_mode_i(slow), .prescaler_source_select_i(pss), .event_input_pin_i(ev),
        .counter_control_reg_wr_i(cwr), .counter_control_reg_i(cd),
        .compare_value_reg_wr_i(mwr), .compare_value_reg_i(md),
        .counter_control_reg_o(ctl), .compare_value_reg_o(cmp), .count_o(cnt),
        .match_interrupt_o(irq), .divider_output_pin_o(pin));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // low-frequency clock stand-in: one strobe every LF_DIV system cycles
    always @(negedge clk_i) begin
        lfc <= (lfc == LF_DIV - 1) ? 0 : lfc + 1;
        lft <= (lfc == LF_DIV - 1);
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hung wait must not stall the run
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // m selects compare write, else control write
    task automatic wr(input bit m, input int ch, input logic [7:0] v);
        @(negedge clk_i);
        if (m) md[ch] = v;
        else cd[ch] = v;
        mwr[ch] = m;
        cwr[ch] = !m;
        @(negedge clk_i);
        mwr[ch] = 1'b0;
        cwr[ch] = 1'b0;
    endtask

    // cycles until the next match pulse or pin change
    task automatic wait_on(input bit use_pin, input int ch, output int cnt_n);
        logic p0;
        p0 = pin[ch];
        cnt_n = 0;
        do begin
            @(negedge clk_i);
            cnt_n++;
        end while ((use_pin ? pin[ch] === p0 : irq[ch] !== 1'b1) && cnt_n < 3000);
        if (cnt_n >= 3000) n_errors++;
    endtask

    function automatic int period(input int shift, input int cmpv);
        return (cmpv == 0 ? 256 : cmpv) << shift;
    endfunction

    initial begin
        rst_b_i = 1'b0;
        ev = 2'b11;
        cwr = '0;
        mwr = '0;
        cd = '0;
        md = '0;
        void'($urandom(32'h4a9c));
        tv = '{1, 255, 2 + int'($urandom % 60)};
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        check("reset ctrl", ctl, 16'h0000);
        check("reset irq and pin", {irq, pin}, 4'h3);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(1, 0, 8'(tv[i]));
            wr(0, 0, {1'b0, tsel[i], 4'h0});
            wr(0, 0, {1'b0, tsel[i], 4'h8});
            wait_on(0, 0, n);
            wait_on(0, 0, n);
            check("timer period", n, period(tsh[i], tv[i]));
            wr(0, 0, {1'b0, tsel[i], 4'h0});
        end
        $display("test timer done");
        nev = 5 + int'($urandom % 5);
        wr(1, 0, 8'h04);
        wr(0, 0, 8'h70);
        wr(0, 0, 8'h78);
        k = 0;
        repeat (nev) for (int j = 0; j < 6; j++) begin
            ev[0] = (j >= 3);
            @(negedge clk_i);
            k += irq[0];
        end
        repeat (8) begin
            @(negedge clk_i);
            k += irq[0];
        end
        check("event count", cnt[0], nev % 4);
        check("event matches", k, nev / 4);
        wr(0, 0, 8'h70);
        $display("test event done");
        k = 2 + int'($urandom % 20);
        wr(1, 1, 8'(k));
        check("compare readback", cmp[1], k);
        wr(0, 1, 8'h31);
        wr(0, 1, 8'h39);
        wait_on(1, 1, n);
        wait_on(1, 1, n);
        check("divider half one", n, period(3, k));
        wait_on(1, 1, n);
        check("divider half two", n, period(3, k));
        p = pin[1];
        wr(0, 1, 8'h31);
        repeat (3) @(negedge clk_i);
        check("pin held", pin[1], p);
        check("stopped count", cnt[1], 8'h00);
        wr(0, 1, 8'h31);
        check("pin forced high", pin[1], 1'b1);
        wr(0, 1, 8'hb1);
        check("pin forced low", pin[1], 1'b0);
        wr(0, 1, 8'h01);
        $display("test divider done");
        wr(1, 0, 8'h03);
        wr(1, 1, 8'h01);
        wr(0, 0, 8'h60);
        wr(0, 1, 8'h04);
        wr(0, 1, 8'h0c);
        check("control readback", ctl[1], 8'h0c);
        wait_on(0, 1, n);
        wait_on(0, 1, n);
        check("chained period", n, period(0, 259));
        wr(0, 1, 8'h04);
        wr(0, 1, 8'h00);
        $display("test chain done");
        foreach (modes[i]) begin
            wr(0, 0, 8'h60 | modes[i]);
            wr(0, 0, 8'h68 | modes[i]);
            repeat (20) @(negedge clk_i);
            check("idle mode count", cnt[0], 8'h00);
            wr(0, 0, 8'h60 | modes[i]);
        end
        $display("test modes done");
        // slow mode, then slow tap forced in fast mode: divider on the slowest tap
        for (int i = 0; i < 2; i++) begin
            slow = (i == 0);
            pss = (i == 1);
            k = 2 + int'($urandom % 4);
            wr(1, 0, 8'(k));
            wr(0, 0, 8'h01);
            wr(0, 0, 8'h09);
            wait_on(1, 0, n);
            wait_on(1, 0, n);
            check("slow divider half", n, period(3, k) * LF_DIV);
            wr(0, 0, 8'h01);
        end
        slow = 1'b0;
        pss = 1'b0;
        $display("test slow done");
        wr(0, 1, 8'h39);
        repeat (20) @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        check("mid-run reset", {ctl[1], cmp[1], cnt[1], irq, pin}, 28'h000_0003);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule // tb_dual_eight_bit_timer_counter

`default_nettype wire
